// ==== core/tscp_core.sv ====
// Purpose: Four-wire serial control port with temperature sensor and GPO logic
// Assumes: Serial pins and analog status come from outside the clock domain
// Notes:   SCLK is oversampled; it must stay well below a quarter of CLK
//
// Function
// - Frame: read bit, 5-bit address, 26 data
// - Sample DIN on each SCLK rise while CS low
// - CS rise after a 32-bit write stores data at address
// - Read shifts register out on SCLK falls
// - No register reset; host writes all
// - Enable bit 14 powers and keeps sensor
// - Misc bit 6 rising starts conversion
// - Five-bit result ready within 2 us
// - Result read back in misc bits 11:7
// - Three GPOs; third may show PLL lock

`timescale 1ns/1ps

module tscp_core (
  input  wire logic                           CLK,
  input  wire logic                           RST_B,
  input  wire logic                           SCLK,
  input  wire logic                           CS_B,
  input  wire logic                           DIN,
  input  wire logic                           RX_LOCK,
  input  wire logic                           TX_LOCK,
  input  wire logic [tscp_pkg::TEMP_W-1:0]    TEMP_CODE,
  output logic                                DOUT,
  output logic      [tscp_pkg::GPO_N-1:0]     GPO,
  output logic                                TEMP_SENSOR_ON,
  output logic                                TEMP_CONVERTING
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int SW = 5 + tscp_pkg::TEMP_W;

  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  logic [SW-1:0] in_raw;

  assign in_raw = {SCLK, CS_B, DIN, RX_LOCK, TX_LOCK, TEMP_CODE};

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_sync
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          // Chip select rests high so reset release opens no false frame
          sync_a[gi] <= (gi == SW - 2);
          sync_b[gi] <= (gi == SW - 2);
        end else begin
          sync_a[gi] <= in_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic                        sclk_s;
  logic                        cs_b_s;
  logic                        din_s;
  logic                        rx_lock_s;
  logic                        tx_lock_s;
  logic [tscp_pkg::TEMP_W-1:0] temp_code_s;

  assign {sclk_s, cs_b_s, din_s, rx_lock_s, tx_lock_s, temp_code_s} = sync_b;

  // ---------------------------------------------------------------
  // Serial frame engine
  // ---------------------------------------------------------------
  tscp_pkg::tscp_frame_state_t        fr_state;
  tscp_pkg::tscp_frame_state_t        next_fr_state;
  logic                               sclk_prev;
  logic [tscp_pkg::FRAME_BITS-1:0]    shift_in;
  logic [tscp_pkg::FRAME_BITS-1:0]    next_shift_in;
  logic [tscp_pkg::CNT_W-1:0]         bit_cnt;
  logic [tscp_pkg::CNT_W-1:0]         next_bit_cnt;
  logic [tscp_pkg::DATA_W-1:0]        shift_out;
  logic [tscp_pkg::DATA_W-1:0]        next_shift_out;
  logic                               next_dout;
  logic                               load_pend;
  logic                               next_load_pend;
  logic                               sclk_rise;
  logic                               sclk_fall;
  logic                               wr_en;
  logic                               rd_en;
  logic [tscp_pkg::ADDR_W-1:0]        rd_addr;
  logic [tscp_pkg::DATA_W-1:0]        rd_data;
  logic [tscp_pkg::DATA_W-1:0]        rd_view;
  tscp_pkg::tscp_frame_t              frame;

  assign sclk_rise = sclk_s & ~sclk_prev;
  assign sclk_fall = ~sclk_s & sclk_prev;
  assign frame     = shift_in;
  assign rd_addr   = {shift_in[3:0], din_s};

  always_comb begin
    next_fr_state  = fr_state;
    next_shift_in  = shift_in;
    next_bit_cnt   = bit_cnt;
    next_shift_out = shift_out;
    next_dout      = DOUT;
    next_load_pend = 1'b0;
    wr_en          = 1'b0;
    rd_en          = 1'b0;
    case (fr_state)
      tscp_pkg::FR_IDLE: begin
        next_dout = 1'b0;
        if (!cs_b_s) begin
          next_fr_state = tscp_pkg::FR_ACTIVE;
          next_bit_cnt  = '0;
        end
      end
      tscp_pkg::FR_ACTIVE: begin
        if (cs_b_s) begin
          next_fr_state = tscp_pkg::FR_IDLE;
          // Only a complete write frame touches storage
          wr_en = (bit_cnt == tscp_pkg::CNT_FULL) && !frame.read;
        end else begin
          if (sclk_rise) begin
            next_shift_in = {shift_in[tscp_pkg::FRAME_BITS-2:0], din_s};
            if (bit_cnt <= tscp_pkg::CNT_FULL) begin
              next_bit_cnt = bit_cnt + 6'h01;
            end
            // Last address bit arriving and the frame is a read
            if (bit_cnt == tscp_pkg::CNT_ADDR && shift_in[4]) begin
              rd_en = 1'b1;
            end
          end
          if (load_pend) begin
            next_shift_out = rd_view;
          end else if (sclk_fall) begin
            next_dout      = shift_out[tscp_pkg::DATA_W-1];
            next_shift_out = {shift_out[tscp_pkg::DATA_W-2:0], 1'b0};
          end
        end
        next_load_pend = rd_en;
      end
      default: begin
        next_fr_state = tscp_pkg::FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fr_state  <= tscp_pkg::FR_IDLE;
      sclk_prev <= 1'b0;
      shift_in  <= '0;
      bit_cnt   <= '0;
      shift_out <= '0;
      DOUT      <= 1'b0;
      load_pend <= 1'b0;
    end else begin
      fr_state  <= next_fr_state;
      sclk_prev <= sclk_s;
      shift_in  <= next_shift_in;
      bit_cnt   <= next_bit_cnt;
      shift_out <= next_shift_out;
      DOUT      <= next_dout;
      load_pend <= next_load_pend;
    end
  end

  // No reset on storage: host must program every register
  tscp_regfile #(
    .AW (tscp_pkg::ADDR_W),
    .DW (tscp_pkg::DATA_W)
  ) u_regs (
    .CLK   (CLK),
    .RST_B (RST_B),
    .WE    (wr_en),
    .WADDR (frame.addr),
    .WDATA (frame.data),
    .RE    (rd_en),
    .RADDR (rd_addr),
    .RDATA (rd_data)
  );

  // ---------------------------------------------------------------
  // Shadow control bits and temperature sensor
  // ---------------------------------------------------------------
  tscp_pkg::tscp_temp_state_t   tc_state;
  tscp_pkg::tscp_temp_state_t   next_tc_state;
  logic                         temp_on;
  logic                         next_temp_on;
  logic                         trig_bit;
  logic                         next_trig_bit;
  logic [4:0]                   gpo_cfg;
  logic [4:0]                   next_gpo_cfg;
  logic [tscp_pkg::TCNT_W-1:0]  tc_cnt;
  logic [tscp_pkg::TCNT_W-1:0]  next_tc_cnt;
  logic [tscp_pkg::TEMP_W-1:0]  temp_res;
  logic [tscp_pkg::TEMP_W-1:0]  next_temp_res;
  logic                         rd_is_misc;
  logic                         next_rd_is_misc;
  logic                         trig;

  assign trig = wr_en && frame.addr == tscp_pkg::OFS_RX_MISC_SEC
                && frame.data[tscp_pkg::BIT_TEMP_TRIG] && !trig_bit;

  always_comb begin
    rd_view = rd_data;
    if (rd_is_misc) begin
      rd_view[tscp_pkg::TEMP_LSB +: tscp_pkg::TEMP_W] = temp_res;
    end
  end

  always_comb begin
    next_temp_on    = temp_on;
    next_trig_bit   = trig_bit;
    next_gpo_cfg    = gpo_cfg;
    next_tc_state   = tc_state;
    next_tc_cnt     = tc_cnt;
    next_temp_res   = temp_res;
    next_rd_is_misc = rd_is_misc;
    if (rd_en) begin
      next_rd_is_misc = (rd_addr == tscp_pkg::OFS_RX_MISC_SEC);
    end
    if (wr_en) begin
      case (frame.addr)
        tscp_pkg::OFS_RX_ENABLE:   next_temp_on  = frame.data[tscp_pkg::BIT_TEMP_ON];
        tscp_pkg::OFS_RX_MISC_SEC: next_trig_bit = frame.data[tscp_pkg::BIT_TEMP_TRIG];
        tscp_pkg::OFS_GPO_CONFIG:  next_gpo_cfg  = frame.data[4:0];
        default:                   next_gpo_cfg  = gpo_cfg;
      endcase
    end
    case (tc_state)
      tscp_pkg::TC_IDLE: begin
        if (trig) begin
          next_tc_state = tscp_pkg::TC_CONV;
          next_tc_cnt   = '0;
        end
      end
      tscp_pkg::TC_CONV: begin
        next_tc_cnt = tc_cnt + 8'h01;
        if (tc_cnt == tscp_pkg::TEMP_CONV_LAST) begin
          next_tc_state = tscp_pkg::TC_IDLE;
          next_temp_res = temp_code_s;
        end
      end
      default: begin
        next_tc_state = tscp_pkg::TC_IDLE;
      end
    endcase
    // Result is held only while the sensor stays powered
    if (!temp_on) begin
      next_temp_res = '0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tc_state        <= tscp_pkg::TC_IDLE;
      temp_on         <= 1'b0;
      trig_bit        <= 1'b0;
      gpo_cfg         <= '0;
      tc_cnt          <= '0;
      temp_res        <= '0;
      rd_is_misc      <= 1'b0;
      TEMP_SENSOR_ON  <= 1'b0;
      TEMP_CONVERTING <= 1'b0;
    end else begin
      tc_state        <= next_tc_state;
      temp_on         <= next_temp_on;
      trig_bit        <= next_trig_bit;
      gpo_cfg         <= next_gpo_cfg;
      tc_cnt          <= next_tc_cnt;
      temp_res        <= next_temp_res;
      rd_is_misc      <= next_rd_is_misc;
      TEMP_SENSOR_ON  <= next_temp_on;
      TEMP_CONVERTING <= (next_tc_state == tscp_pkg::TC_CONV);
    end
  end

  // ---------------------------------------------------------------
  // General-purpose outputs
  // ---------------------------------------------------------------
  logic [tscp_pkg::GPO_N-1:0] next_gpo;
  tscp_pkg::tscp_third_general_output_mode_t  third_general_output_mode;

  assign third_general_output_mode = tscp_pkg::tscp_third_general_output_mode_t'(gpo_cfg[tscp_pkg::GPO_MODE_LSB +: 2]);

  always_comb begin
    next_gpo = gpo_cfg[tscp_pkg::GPO_N-1:0];
    case (third_general_output_mode)
      tscp_pkg::THIRD_GENERAL_OUTPUT_RX_LOCK: next_gpo[2] = rx_lock_s;
      tscp_pkg::THIRD_GENERAL_OUTPUT_TX_LOCK: next_gpo[2] = tx_lock_s;
      tscp_pkg::THIRD_GENERAL_OUTPUT_BOTH:    next_gpo[2] = rx_lock_s & tx_lock_s;
      default:                next_gpo[2] = gpo_cfg[2];
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      GPO <= '0;
    end else begin
      GPO <= next_gpo;
    end
  end

endmodule : tscp_core

// ==== core/tscp_pkg.sv ====
// Purpose: Shared constants and types of the transceiver serial control port
// Assumes: 100 MHz system clock
// Notes:   Register contents themselves have no reset value

package tscp_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 5;
  localparam int DATA_W      = 26;
  localparam int FRAME_BITS  = 1 + ADDR_W + DATA_W;
  localparam int CNT_W       = 6;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
  localparam logic [CNT_W-1:0] CNT_ADDR = 6'h05;

  typedef struct packed {
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } tscp_frame_t;

  // ---------------------------------------------------------------
  // Register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_RX_ENABLE    = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_GPO_CONFIG   = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_RX_MISC_SEC  = 5'h08;
  localparam int BIT_TEMP_ON      = 14;
  localparam int BIT_TEMP_TRIG    = 6;
  localparam int TEMP_LSB         = 7;
  localparam int TEMP_W           = 5;
  localparam int GPO_N            = 3;
  localparam int GPO_MODE_LSB     = 3;

  typedef enum logic [1:0] {
    THIRD_GENERAL_OUTPUT_PLAIN   = 2'h0,
    THIRD_GENERAL_OUTPUT_RX_LOCK = 2'h1,
    THIRD_GENERAL_OUTPUT_TX_LOCK = 2'h2,
    THIRD_GENERAL_OUTPUT_BOTH    = 2'h3
  } tscp_third_general_output_mode_t;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 10000;
  localparam int TEMP_CONV_US    = 2;
  localparam int TEMP_CONV_CYC   = (TEMP_CONV_US * 1000000) / CLK_PERIOD_PS;
  localparam int TCNT_W          = 8;
  localparam logic [TCNT_W-1:0] TEMP_CONV_LAST = TCNT_W'(TEMP_CONV_CYC - 1);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FR_IDLE   = 2'b01,
    FR_ACTIVE = 2'b10
  } tscp_frame_state_t;

  typedef enum logic [1:0] {
    TC_IDLE = 2'b01,
    TC_CONV = 2'b10
  } tscp_temp_state_t;

endpackage : tscp_pkg

// ==== core/tscp_regfile.sv ====
// Purpose: 32 x 26 register storage with registered read data
// Assumes: One write and one read port on the system clock
// Notes:   Storage is never reset; only the read register is

`timescale 1ns/1ps

module tscp_regfile #(
  parameter int AW = 5,
  parameter int DW = 26
) (
  input  wire logic          CLK,
  input  wire logic          RST_B,
  input  wire logic          WE,
  input  wire logic [AW-1:0] WADDR,
  input  wire logic [DW-1:0] WDATA,
  input  wire logic          RE,
  input  wire logic [AW-1:0] RADDR,
  output logic      [DW-1:0] RDATA
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] next_rdata;

  // Contents undefined until the host writes them
  always_ff @(posedge CLK) begin
    if (WE) begin
      mem[WADDR] <= WDATA;
    end
  end

  always_comb begin
    next_rdata = RDATA;
    if (RE) begin
      next_rdata = mem[RADDR];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= '0;
    end else begin
      RDATA <= next_rdata;
    end
  end

endmodule : tscp_regfile

// ==== test/tscp_core_props.sv ====
// Purpose: Port assertions for the serial control port
// Assumes: Bound to tscp_core, one CLK domain
// Notes:   Helper counters only, no stimulus
`timescale 1ns/1ps

module tscp_core_props (
  input wire logic                        CLK,
  input wire logic                        RST_B,
  input wire logic                        SCLK,
  input wire logic                        CS_B,
  input wire logic                        DIN,
  input wire logic                        RX_LOCK,
  input wire logic                        TX_LOCK,
  input wire logic [tscp_pkg::TEMP_W-1:0] TEMP_CODE,
  input wire logic                        DOUT,
  input wire logic [tscp_pkg::GPO_N-1:0]  GPO,
  input wire logic                        TEMP_SENSOR_ON,
  input wire logic                        TEMP_CONVERTING
);
  logic [7:0] conv_cnt;
  logic [7:0] next_conv_cnt;
  logic [2:0] hi_cnt;
  logic [2:0] next_hi_cnt;

  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  always_comb begin
    next_conv_cnt = TEMP_CONVERTING ? conv_cnt + 8'h01 : 8'h00;
    next_hi_cnt   = !SCLK ? 3'h0 : (hi_cnt == 3'h7) ? hi_cnt : hi_cnt + 3'h1;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      conv_cnt <= 8'h00;
      hi_cnt   <= 3'h0;
    end else begin
      conv_cnt <= next_conv_cnt;
      hi_cnt   <= next_hi_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_idle_dout_low: assert property (CS_B [*8] |-> !DOUT)
    else $error("DOUT driven while deselected");
  a_dout_on_fall: assert property (!CS_B && $changed(DOUT) |-> hi_cnt < 3'h3)
    else $error("DOUT moved late in SCLK high phase");
  a_conv_length: assert property ($fell(TEMP_CONVERTING) |-> conv_cnt == 8'hC8)
    else $error("Conversion length wrong");
  a_conv_steady: assert property ($rose(TEMP_CONVERTING) |=> TEMP_CONVERTING [*8])
    else $error("Conversion dropped early");
  a_conv_trigger: assert property ($rose(TEMP_CONVERTING) |-> CS_B)
    else $error("Conversion started inside a frame");
  a_gpo_on_write: assert property ($changed(GPO[1:0]) |-> CS_B)
    else $error("GPO levels changed mid frame");
  a_sensor_write: assert property ($changed(TEMP_SENSOR_ON) |-> CS_B)
    else $error("Sensor enable changed mid frame");
  a_reset_quiet: assert property ($rose(RST_B) |-> !DOUT && GPO == 3'h0 && !TEMP_CONVERTING)
    else $error("Outputs not quiet after reset");
endmodule : tscp_core_props

// ==== test/tscp_core_test.sv ====
// Purpose: Self-checking bench of the serial control port
// Assumes: 100 MHz CLK, host model drives the serial lines
// Notes:   Storage has no reset, so all registers are written first
`timescale 1ns/1ps

module tscp_core_test;
  logic       clk;
  logic       rst_b;
  logic       rx_lock;
  logic       tx_lock;
  logic [4:0] temp_code;
  logic       sclk;
  logic       cs_b;
  logic       din;
  logic       dout;
  logic [2:0] gpo;
  logic       sensor_on;
  logic       converting;
  int         bad_count;
  int         check_count;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  tscp_host_model host (.CLK(clk), .SCLK(sclk), .CS_B(cs_b), .DIN(din), .DOUT(dout));

  tscp_core dut (
    .CLK(clk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b), .DIN(din),
    .RX_LOCK(rx_lock), .TX_LOCK(tx_lock), .TEMP_CODE(temp_code), .DOUT(dout),
    .GPO(gpo), .TEMP_SENSOR_ON(sensor_on), .TEMP_CONVERTING(converting)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [25:0] d);
    logic [25:0] q;
    host.frame({1'b0, a, d}, 32, q);
  endtask : wr

  // Data bits all ones: a read must ignore them
  task automatic rd(input logic [4:0] a, input logic [25:0] exp);
    logic [25:0] q;
    host.frame({1'b1, a, 26'h3FFFFFF}, 32, q);
    chk(q, exp, "readback");
  endtask : rd

  function automatic logic [25:0] pat(input logic [4:0] a);
    return {a, 21'h1A8043};
  endfunction : pat

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    logic [25:0] q;
    logic [25:0] modes [6];
    logic [4:0]  cfg_a [8];
    logic [25:0] cfg_d [8];
    logic [2:0]  lvl;
    logic        e2;
    int          n;
    modes     = '{26'h0000000, 26'h0000840, 26'h0001000, 26'h0079BFF, 26'h00009FF, 26'h0079240};
    cfg_a     = '{5'h14, 5'h1E, 5'h10, 5'h18, 5'h1D, 5'h03, 5'h1C, 5'h0F};
    cfg_d     = '{26'h1000000, 26'h0080000, 26'h0100000, 26'h0040000,
                  26'h0003000, 26'h0340000, 26'h000E000, 26'h0400040};
    rst_b     = 1'b0;
    rx_lock   = 1'b0;
    tx_lock   = 1'b0;
    temp_code = 5'h15;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (10000) @(negedge clk);
    for (int a = 0; a < 32; a++) wr(5'(a), pat(5'(a)));
    for (int a = 0; a < 32; a++) rd(5'(a), pat(5'(a)));
    $display("test write and readback done");
    host.frame({1'b0, 5'h05, 26'h0ABCDEF}, 20, q);
    host.frame({1'b0, 5'h05, 26'h0ABCDEF}, 31, q);
    rd(5'h05, pat(5'h05));
    $display("test short frame done");
    for (int i = 0; i < 6; i++) begin
      wr(5'h00, modes[i]);
      rd(5'h00, modes[i]);
    end
    // Full duplex settings: bias, AFC DAC, data recovery, reference, bands, dither
    for (int i = 0; i < 8; i++) begin
      wr(cfg_a[i], cfg_d[i]);
      rd(cfg_a[i], cfg_d[i]);
    end
    $display("test power modes done");
    wr(5'h00, 26'h0004000);
    chk({25'h0, sensor_on}, 26'h1, "sensor on");
    wr(5'h08, 26'h0001000);
    wr(5'h08, 26'h0001040);
    chk({25'h0, converting}, 26'h1, "conversion start");
    n = 0;
    while (converting !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      $display("BAD %0t conversion too long", $time);
      tally_and_finish();
    end
    // Result must be the captured code, not the live one
    temp_code = 5'h0A;
    rd(5'h08, 26'h0001040 | {14'h0, 5'h15, 7'h0});
    wr(5'h00, 26'h0000000);
    rd(5'h08, 26'h0001040);
    $display("test temperature done");
    for (int m = 0; m < 4; m++) begin
      for (int l = 0; l < 4; l++) begin
        rx_lock = l[0];
        tx_lock = l[1];
        lvl     = {l[0] ^ m[0], ~m[0], m[1]};
        wr(5'h07, {21'h0, m[1:0], lvl});
        repeat (8) @(negedge clk);
        e2 = (m == 0) ? lvl[2] : (m == 1) ? l[0] : (m == 2) ? l[1] : (l[0] & l[1]);
        chk({23'h0, gpo}, {23'h0, e2, lvl[1:0]}, "gpo");
      end
    end
    $display("test gpo done");
    tally_and_finish();
  end
endmodule : tscp_core_test

bind tscp_core tscp_core_props chk_props (
  .CLK(CLK), .RST_B(RST_B), .SCLK(SCLK), .CS_B(CS_B), .DIN(DIN),
  .RX_LOCK(RX_LOCK), .TX_LOCK(TX_LOCK), .TEMP_CODE(TEMP_CODE), .DOUT(DOUT),
  .GPO(GPO), .TEMP_SENSOR_ON(TEMP_SENSOR_ON), .TEMP_CONVERTING(TEMP_CONVERTING)
);

// ==== test/tscp_host_model.sv ====
// Purpose: Host side of the four-wire serial link
// Assumes: SCLK period of 8 CLK periods
// Notes:   SCLK stands low between frames
`timescale 1ns/1ps

module tscp_host_model (
  input  wire logic CLK,
  output logic      SCLK,
  output logic      CS_B,
  output logic      DIN,
  input  wire logic DOUT
);
  initial begin
    SCLK = 1'b0;
    CS_B = 1'b1;
    DIN  = 1'b0;
  end

  // ---------------------------------------------------------------
  // Frame
  // ---------------------------------------------------------------
  // Short counts allowed so truncated frames can be sent
  task automatic frame(input logic [31:0] w, input int n, output logic [25:0] q);
    q    = 26'h0;
    CS_B = 1'b0;
    for (int k = 0; k < n; k++) begin
      DIN = w[31-k];
      repeat (4) @(negedge CLK);
      SCLK = 1'b1;
      repeat (4) @(negedge CLK);
      if (k >= 6) q[31-k] = DOUT;
      SCLK = 1'b0;
    end
    repeat (4) @(negedge CLK);
    CS_B = 1'b1;
    // Released line shows no stale bit
    DIN  = ~DIN;
    repeat (12) @(negedge CLK);
  endtask : frame
endmodule : tscp_host_model
